// *** design/scbr_pkg.sv ***
// Contract
// - Phase 0 changes data on first clock edge, samples next; phase 1 the reverse.
// - Polarity bit sets serial clock idle level: 0 low, 1 high.
// - Bit-order bit: 0 shifts LSB first, 1 MSB first, both directions.
// - Character length bit: 0 gives 8-bit, 1 gives 7-bit characters.
// - Pin mode: 00 3-pin, 01 enable high, 10 enable low, 11 I2C.
// - Synchronous enable bit picks async (0) or sync (1); resets to 1.
// - Source select: 00 external clock, 01 auxiliary, 10/11 sub-main; resets to 3.
// - In 4-pin master, enable-pin role: 0 conflict detect, 1 drive slave enable.
// - Soft reset hold bit holds interface logic in reset; resets to 1.
// - Control and divider fields change only while soft reset hold is set.
// - Bit clock is source divided by divider; zero divider passes source through.
// - Reset values 01C1h, 00h, 02h, 0000h; byte access to control and divider halves.
// - Receive buffer read clears error and receive flags; 7-bit data right-justified.
// - Transmit flag set while transmit buffer empty; buffer write clears it.
// - Bus conflict flag set on conflict in 4-wire master mode only.
package scbr_pkg;
	localparam logic [5:0]  IDX_CTL       = 6'h00;
	localparam logic [5:0]  IDX_CTL_HI    = 6'h01;
	localparam logic [5:0]  IDX_BRW       = 6'h06;
	localparam logic [5:0]  IDX_BRW_HI    = 6'h07;
	localparam logic [5:0]  IDX_STAT      = 6'h08;
	localparam logic [5:0]  IDX_RXBUF     = 6'h0c;
	localparam logic [5:0]  IDX_TXBUF     = 6'h0e;
	localparam logic [5:0]  IDX_IE        = 6'h2a;
	localparam logic [5:0]  IDX_IFG       = 6'h2c;
	localparam logic [5:0]  IDX_IV        = 6'h2e;
	localparam logic [5:0]  IDX_ICLR      = 6'h30;
	localparam int          CTL_CKPH      = 15;
	localparam int          CTL_CKPL      = 14;
	localparam int          CTL_MSB       = 13;
	localparam int          CTL_SEVEN     = 12;
	localparam int          CTL_MST       = 11;
	localparam int          CTL_MODE      = 9;
	localparam int          CTL_SYNC      = 8;
	localparam int          CTL_SSEL      = 6;
	localparam int          CTL_STEM      = 1;
	localparam int          CTL_SWRST     = 0;
	localparam int          ST_LISTEN     = 7;
	localparam int          ST_FE         = 6;
	localparam int          ST_OE         = 5;
	localparam int          IFG_RX        = 0;
	localparam int          IFG_TX        = 1;
	localparam logic [15:0] CTL_RESET     = 16'h01c1;
	localparam logic [15:0] CTL_WMASK     = 16'hffc3;
	localparam logic [15:0] CTL_HOLD_MASK = 16'h0001;
	localparam logic [15:0] BRW_RESET     = 16'h0000;
	localparam logic [15:0] STAT_WMASK    = 16'h00e0;
	localparam logic [15:0] IV_NONE       = 16'h0000;
	localparam logic [15:0] IV_RX         = 16'h0002;
	localparam logic [15:0] IV_TX         = 16'h0004;
	localparam logic [1:0]  IFG_RESET     = 2'h2;
	localparam logic [3:0]  CHAR_LEN8     = 4'h8;
	localparam logic [3:0]  CHAR_LEN7     = 4'h7;
	localparam logic [3:0]  SETTLE_CYC    = 4'h6;
	typedef enum logic [1:0] {
		PM_3PIN    = 2'h0,
		PM_4PIN_HI = 2'h1,
		PM_4PIN_LO = 2'h2,
		PM_I2C     = 2'h3
	} scbr_pin_mode_e;
	typedef enum logic [1:0] {
		SRC_EXT      = 2'h0,
		SRC_AUX      = 2'h1,
		SRC_SUB_MAIN = 2'h2,
		SRC_SUB_ALT  = 2'h3
	} scbr_clk_src_e;
	typedef enum logic [1:0] {
		ENG_IDLE  = 2'h0,
		ENG_LEAD  = 2'h1,
		ENG_TRAIL = 2'h3
	} scbr_state_e;
endpackage

// *** design/scbr_sync.sv ***
module scbr_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             i_clk_sys,
	input  wire logic             i_rstn,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_stage2,
	output logic      [WIDTH-1:0] o_stage3
);
	logic [WIDTH-1:0] stage1;

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			stage1   <= '0;
			o_stage2 <= '0;
			o_stage3 <= '0;
		end else begin
			stage1   <= i_async;
			o_stage2 <= stage1;
			o_stage3 <= o_stage2;
		end
	end
endmodule

// *** design/scbr_top.sv ***
// The Avalon-MM interface to the registers is this design's own decision.
module scbr_top (
	input  wire logic        i_clk_sys,
	input  wire logic        i_rstn,
	input  wire logic [7:0]  i_avs_address,
	input  wire logic        i_avs_read,
	input  wire logic        i_avs_write,
	input  wire logic [31:0] i_avs_writedata,
	input  wire logic [3:0]  i_avs_byteenable,
	output logic      [31:0] o_avs_readdata,
	output logic             o_avs_waitrequest,
	input  wire logic        i_aux_clk_tick,
	input  wire logic        i_sub_main_clk_tick,
	input  wire logic        i_serial_clock_pin,
	output logic             o_serial_clock_pin,
	output logic             o_serial_clock_pin_oe,
	input  wire logic        i_slave_enable_pin,
	output logic             o_slave_enable_pin,
	output logic             o_slave_enable_pin_oe,
	input  wire logic        i_simo_pin,
	output logic             o_simo_pin,
	output logic             o_simo_pin_oe,
	input  wire logic        i_somi_pin,
	output logic             o_somi_pin,
	output logic             o_somi_pin_oe,
	output logic             o_irq
);
	logic [15:0] ctl, brw, dcnt, h_ticks, wd16, be16, rd_val, m_ctl, m_brw;
	logic [7:0]  txb, rxb, tx_sh, rx_sh, rx_nx, tx_shifted;
	logic [3:0]  bcnt, bcnt_nx, nbits, s2, s3, pin, agree, gap;
	logic        settled, tick;
	logic [1:0]  ifg, ie, mode, ssel;
	logic [5:0]  idx, tgt;
	logic        listen, fe, oe, sclk, dout, waitreq;
	logic        ckph, ckpl, msb, seven, mst, stem, swrst;
	logic        eng_on, four_pin, act_hi, ste_act, slave_en, conflict;
	logic        src_tick, bit_tick, clk_edge, lead_ev, trail_ev, samp, chg;
	logic        din, done, start, abort, load, rx_done;
	logic        req, take, acc, wr, rd_rx, tx_wr;
	scbr_pkg::scbr_state_e state;

	// Serial clock, enable, data-in lines arrive from the pins
	scbr_sync #(.WIDTH(4)) u_sync (
		.i_clk_sys (i_clk_sys),
		.i_rstn    (i_rstn),
		.i_async   ({i_serial_clock_pin, i_slave_enable_pin, i_simo_pin, i_somi_pin}),
		.o_stage2  (s2),
		.o_stage3  (s3)
	);

	// A pin level counts only once two later stages agree
	assign agree = ~(s2 ^ s3);

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			pin <= 4'h0;
		end else begin
			pin <= (s2 & agree) | (pin & ~agree);
		end
	end

	assign clk_edge = agree[3] && (s2[3] != pin[3]);

	assign ckph  = ctl[scbr_pkg::CTL_CKPH];
	assign ckpl  = ctl[scbr_pkg::CTL_CKPL];
	assign msb   = ctl[scbr_pkg::CTL_MSB];
	assign seven = ctl[scbr_pkg::CTL_SEVEN];
	assign mst   = ctl[scbr_pkg::CTL_MST];
	assign stem  = ctl[scbr_pkg::CTL_STEM];
	assign swrst = ctl[scbr_pkg::CTL_SWRST];
	assign mode  = ctl[scbr_pkg::CTL_MODE +: 2];
	assign ssel  = ctl[scbr_pkg::CTL_SSEL +: 2];

	// Engine runs only out of hold, in synchronous SPI pin modes
	assign eng_on = !swrst && ctl[scbr_pkg::CTL_SYNC] && (mode != scbr_pkg::PM_I2C);
	assign four_pin = (mode == scbr_pkg::PM_4PIN_HI) || (mode == scbr_pkg::PM_4PIN_LO);
	assign act_hi   = (mode == scbr_pkg::PM_4PIN_HI);
	assign ste_act  = (pin[2] == act_hi);
	assign slave_en = !four_pin || ste_act;
	// Role bit only matters in 4-pin master operation
	assign conflict = eng_on && mst && four_pin && !stem && ste_act;
	assign nbits    = seven ? scbr_pkg::CHAR_LEN7 : scbr_pkg::CHAR_LEN8;

	always_comb begin
		unique case (ssel)
			scbr_pkg::SRC_EXT: src_tick = 1'b0;
			scbr_pkg::SRC_AUX: src_tick = i_aux_clk_tick;
			default:           src_tick = i_sub_main_clk_tick;
		endcase
	end

	// Each clock half lasts long enough for the far side's reply to cross the pin
	// synchronisers before it is sampled; this caps the bit rate at small dividers
	assign settled  = (gap >= scbr_pkg::SETTLE_CYC);
	assign tick     = src_tick && settled;
	// Zero and one both give one source tick per bit
	assign bit_tick = tick && (dcnt == ((brw == 16'h0000) ? 16'h0000 : brw - 16'h0001));

	assign lead_ev  = (state == scbr_pkg::ENG_LEAD)
		&& (mst ? bit_tick : (clk_edge && (s2[3] != ckpl)));
	assign trail_ev = (state == scbr_pkg::ENG_TRAIL)
		&& (mst ? settled : (clk_edge && (s2[3] == ckpl)));
	assign samp = (lead_ev && ckph) || (trail_ev && !ckph);
	assign chg  = (lead_ev && !ckph) || (trail_ev && ckph);
	assign din  = listen ? dout : (mst ? pin[0] : pin[1]);
	assign rx_nx = !samp ? rx_sh : (msb ? {rx_sh[6:0], din} : {din, rx_sh[7:1]});
	assign tx_shifted = msb ? {tx_sh[6:0], 1'b0} : {1'b0, tx_sh[7:1]};
	assign bcnt_nx = bcnt + {3'h0, samp};
	assign done    = trail_ev && (bcnt_nx == nbits);
	assign abort   = (state != scbr_pkg::ENG_IDLE) && (!eng_on || (mst ? conflict : !slave_en));
	// A buffer write in the same cycle would otherwise lose its data
	assign start = (state == scbr_pkg::ENG_IDLE) && eng_on && !tx_wr
		&& (mst ? (!ifg[scbr_pkg::IFG_TX] && !conflict) : slave_en);
	assign load    = start && !ifg[scbr_pkg::IFG_TX];
	assign rx_done = done && !abort;

	function automatic logic out_bit(input logic [7:0] v, input logic m, input logic s);
		out_bit = m ? (s ? v[6] : v[7]) : v[0];
	endfunction

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			state <= scbr_pkg::ENG_IDLE;
			bcnt  <= 4'h0;
			dcnt  <= 16'h0000;
			tx_sh <= 8'h00;
			rx_sh <= 8'h00;
			dout  <= 1'b0;
		end else if (abort || !eng_on) begin
			state <= scbr_pkg::ENG_IDLE;
			bcnt  <= 4'h0;
			dcnt  <= 16'h0000;
		end else begin
			unique case (state)
				scbr_pkg::ENG_IDLE: begin
					if (start) begin
						state <= scbr_pkg::ENG_LEAD;
						dcnt  <= 16'h0000;
					end
					if (load) begin
						tx_sh <= txb;
						dout  <= out_bit(txb, msb, seven);
					end
				end
				scbr_pkg::ENG_LEAD: begin
					if (lead_ev) begin
						state <= scbr_pkg::ENG_TRAIL;
					end
					dcnt <= bit_tick ? 16'h0000 : dcnt + {15'h0000, tick};
				end
				scbr_pkg::ENG_TRAIL: begin
					if (trail_ev) begin
						state <= done ? scbr_pkg::ENG_IDLE : scbr_pkg::ENG_LEAD;
					end
				end
				default: state <= scbr_pkg::ENG_IDLE;
			endcase
			bcnt  <= done ? 4'h0 : bcnt_nx;
			rx_sh <= rx_nx;
			// The first change edge of phase 0 only re-presents the loaded bit
			if (chg && (bcnt != 4'h0)) begin
				tx_sh <= tx_shifted;
				dout  <= out_bit(tx_shifted, msb, seven);
			end
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			rxb <= 8'h00;
		end else if (rx_done) begin
			rxb <= !seven ? rx_nx : (msb ? {1'b0, rx_nx[6:0]} : {1'b0, rx_nx[7:1]});
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			sclk <= 1'b0;
		end else if (!eng_on || (state == scbr_pkg::ENG_IDLE)) begin
			sclk <= ckpl;
		end else if (mst && lead_ev) begin
			sclk <= ~ckpl;
		end else if (mst && trail_ev) begin
			sclk <= ckpl;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			o_serial_clock_pin_oe <= 1'b0;
			o_simo_pin_oe         <= 1'b0;
			o_somi_pin_oe         <= 1'b0;
			o_slave_enable_pin_oe <= 1'b0;
			o_slave_enable_pin    <= 1'b0;
		end else begin
			o_serial_clock_pin_oe <= eng_on && mst;
			o_simo_pin_oe         <= eng_on && mst;
			o_somi_pin_oe         <= eng_on && !mst && slave_en;
			o_slave_enable_pin_oe <= eng_on && mst && four_pin && stem;
			o_slave_enable_pin    <= (state != scbr_pkg::ENG_IDLE) ? act_hi : !act_hi;
		end
	end

	assign o_serial_clock_pin = sclk;
	assign o_simo_pin         = dout;
	assign o_somi_pin         = dout;

	// Bus slave: request taken while waitrequest is high, completed one cycle later
	assign req   = i_avs_read || i_avs_write;
	assign take  = req && waitreq;
	assign acc   = req && !waitreq;
	assign wr    = acc && i_avs_write;
	assign idx   = i_avs_address[7:2];
	assign rd_rx = take && i_avs_read && (idx == scbr_pkg::IDX_RXBUF);
	assign tx_wr = wr && (tgt == scbr_pkg::IDX_TXBUF) && be16[0];

	always_comb begin
		tgt  = idx;
		wd16 = i_avs_writedata[15:0];
		be16 = {{8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
		if ((idx == scbr_pkg::IDX_CTL_HI) || (idx == scbr_pkg::IDX_BRW_HI)) begin
			tgt  = idx - 6'h01;
			wd16 = {i_avs_writedata[7:0], 8'h00};
			be16 = {{8{i_avs_byteenable[0]}}, 8'h00};
		end
	end

	assign m_ctl = be16 & (swrst ? scbr_pkg::CTL_WMASK : scbr_pkg::CTL_HOLD_MASK);
	assign m_brw = be16 & {16{swrst}};

	always_comb begin
		unique case (idx)
			scbr_pkg::IDX_CTL:    rd_val = ctl;
			scbr_pkg::IDX_CTL_HI: rd_val = {8'h00, ctl[15:8]};
			scbr_pkg::IDX_BRW:    rd_val = brw;
			scbr_pkg::IDX_BRW_HI: rd_val = {8'h00, brw[15:8]};
			scbr_pkg::IDX_STAT:
				rd_val = {8'h00, listen, fe, oe, 4'h0, state != scbr_pkg::ENG_IDLE};
			scbr_pkg::IDX_RXBUF:  rd_val = {8'h00, rxb};
			scbr_pkg::IDX_TXBUF:  rd_val = {8'h00, txb};
			scbr_pkg::IDX_IE:     rd_val = {14'h0000, ie};
			scbr_pkg::IDX_IFG:    rd_val = {14'h0000, ifg};
			scbr_pkg::IDX_IV:
				rd_val = ifg[scbr_pkg::IFG_RX] ? scbr_pkg::IV_RX
					: (ifg[scbr_pkg::IFG_TX] ? scbr_pkg::IV_TX : scbr_pkg::IV_NONE);
			default:              rd_val = 16'h0000;
		endcase
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			waitreq        <= 1'b1;
			o_avs_readdata <= 32'h0000_0000;
		end else begin
			waitreq <= !take;
			if (take) begin
				o_avs_readdata <= {16'h0000, i_avs_read ? rd_val : 16'h0000};
			end
		end
	end

	assign o_avs_waitrequest = waitreq;

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			ctl <= scbr_pkg::CTL_RESET;
			brw <= scbr_pkg::BRW_RESET;
		end else if (wr && (tgt == scbr_pkg::IDX_CTL)) begin
			ctl <= (ctl & ~m_ctl) | (wd16 & m_ctl);
		end else if (wr && (tgt == scbr_pkg::IDX_BRW)) begin
			brw <= (brw & ~m_brw) | (wd16 & m_brw);
		end
	end

	// Hardware sets are applied last so an event never loses to a clear
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			listen <= 1'b0;
			fe     <= 1'b0;
			oe     <= 1'b0;
		end else begin
			if (wr && (tgt == scbr_pkg::IDX_STAT) && swrst) begin
				listen <= be16[scbr_pkg::ST_LISTEN] ? wd16[scbr_pkg::ST_LISTEN] : listen;
				fe     <= be16[scbr_pkg::ST_FE] ? wd16[scbr_pkg::ST_FE] : fe;
				oe     <= be16[scbr_pkg::ST_OE] ? wd16[scbr_pkg::ST_OE] : oe;
			end else if (swrst) begin
				fe <= 1'b0;
				oe <= 1'b0;
			end else if (rd_rx) begin
				fe <= 1'b0;
				oe <= 1'b0;
			end
			if (conflict) begin
				fe <= 1'b1;
			end
			if (rx_done && ifg[scbr_pkg::IFG_RX]) begin
				oe <= 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			txb <= 8'h00;
		end else if (tx_wr) begin
			txb <= seven ? {1'b0, wd16[6:0]} : wd16[7:0];
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			ie <= 2'h0;
		end else if (wr && (tgt == scbr_pkg::IDX_IE) && be16[0]) begin
			ie <= wd16[1:0];
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			ifg <= scbr_pkg::IFG_RESET;
		end else if (swrst) begin
			ifg <= scbr_pkg::IFG_RESET;
		end else begin
			if (wr && (tgt == scbr_pkg::IDX_ICLR) && be16[0]) begin
				ifg <= ifg & ~wd16[1:0];
			end
			if (rd_rx) begin
				ifg[scbr_pkg::IFG_RX] <= 1'b0;
			end
			if (tx_wr) begin
				ifg[scbr_pkg::IFG_TX] <= 1'b0;
			end
			if (load) begin
				ifg[scbr_pkg::IFG_TX] <= 1'b1;
			end
			if (rx_done) begin
				ifg[scbr_pkg::IFG_RX] <= 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= |(ifg & ie);
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			gap <= 4'h0;
		end else if ((state == scbr_pkg::ENG_IDLE) || lead_ev || trail_ev) begin
			gap <= 4'h0;
		end else if (!settled) begin
			gap <= gap + 4'h1;
		end
	end

	// Settled source ticks seen since entering the lead state, for checking only
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			h_ticks <= 16'h0000;
		end else if ((state != scbr_pkg::ENG_LEAD) || lead_ev) begin
			h_ticks <= 16'h0000;
		end else if (tick) begin
			h_ticks <= h_ticks + 16'h0001;
		end
	end

	sequence s_rx_read;
		rd_rx && !rx_done && !conflict;
	endsequence

	sequence s_lead;
		lead_ev && !abort;
	endsequence

	property p_phase;
		@(posedge i_clk_sys) disable iff (!i_rstn)
		s_lead |=> (bcnt == ($past(bcnt) + {3'h0, $past(ckph)}));
	endproperty
	a_phase: assert property (p_phase) else $error("sample count wrong on lead edge");

	property p_idle_level;
		@(posedge i_clk_sys) disable iff (!i_rstn)
		(state == scbr_pkg::ENG_IDLE) |=> (o_serial_clock_pin == $past(ckpl));
	endproperty
	a_idle_level: assert property (p_idle_level) else $error("idle clock level wrong");

	property p_first_bit;
		@(posedge i_clk_sys) disable iff (!i_rstn)
		load |=> (o_simo_pin == $past(msb ? (seven ? txb[6] : txb[7]) : txb[0]));
	endproperty
	a_first_bit: assert property (p_first_bit) else $error("first bit order wrong");

	property p_hold;
		@(posedge i_clk_sys) disable iff (!i_rstn)
		swrst |=> ((state == scbr_pkg::ENG_IDLE) && (ifg == scbr_pkg::IFG_RESET));
	endproperty
	a_hold: assert property (p_hold) else $error("logic not held in reset");

	property p_locked;
		@(posedge i_clk_sys) disable iff (!i_rstn)
		!swrst |=> ($stable(ctl[15:1]) && $stable(brw));
	endproperty
	a_locked: assert property (p_locked) else $error("config changed outside hold");

	property p_divider;
		@(posedge i_clk_sys) disable iff (!i_rstn)
		(lead_ev && mst) |-> (src_tick
			&& (h_ticks == ((brw == 16'h0000) ? 16'h0000 : brw - 16'h0001)));
	endproperty
	a_divider: assert property (p_divider) else $error("bit clock divide wrong");

	property p_overrun;
		@(posedge i_clk_sys) disable iff (!i_rstn)
		(rx_done && ifg[scbr_pkg::IFG_RX]) |=> oe;
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun not flagged");

	property p_rx_read;
		@(posedge i_clk_sys) disable iff (!i_rstn)
		s_rx_read |=> (!ifg[scbr_pkg::IFG_RX] && !oe && !fe);
	endproperty
	a_rx_read: assert property (p_rx_read) else $error("read did not clear flags");

	property p_tx_flag;
		@(posedge i_clk_sys) disable iff (!i_rstn)
		(tx_wr && !swrst) |=> !ifg[scbr_pkg::IFG_TX] ##1 1'b1;
	endproperty
	a_tx_flag: assert property (p_tx_flag) else $error("tx flag not cleared");

	property p_conflict;
		@(posedge i_clk_sys) disable iff (!i_rstn)
		conflict |=> (fe && (state == scbr_pkg::ENG_IDLE));
	endproperty
	a_conflict: assert property (p_conflict) else $error("conflict not handled");

	property p_slave_edge;
		@(posedge i_clk_sys) disable iff (!i_rstn)
		((state == scbr_pkg::ENG_LEAD) && !mst && eng_on && slave_en && clk_edge
			&& (s2[3] != ckpl)) |=> (state == scbr_pkg::ENG_TRAIL);
	endproperty
	a_slave_edge: assert property (p_slave_edge) else $error("slave missed clock edge");
endmodule

// *** testbench/scbr_peer.sv ***
module scbr_peer (
	input  wire logic       i_clk_sys,
	input  wire logic       i_clr,
	input  wire logic       i_sclk,
	input  wire logic       i_simo,
	input  wire logic       i_cpha,
	input  wire logic       i_cpol,
	input  wire logic       i_msb,
	input  wire logic       i_seven,
	input  wire logic [7:0] i_reply,
	output logic            o_somi,
	output logic      [7:0] o_rx,
	output int              o_chars
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       prev = 1'b0;
	logic [7:0] sh = 8'h00;
	int         n = 0;
	initial o_chars = 0;
	initial o_somi = 1'b0;
	initial o_rx = 8'h00;
	function automatic int pos(input int k);
		int len;
		len = i_seven ? 7 : 8;
		return i_msb ? len - 1 - k : k;
	endfunction
	// Slave sees the clock itself, so it shifts on every pin edge it observes
	always @(posedge i_clk_sys) begin
		prev <= i_sclk;
		if (i_clr) begin
			n = 0;
			sh = 8'h00;
			o_somi <= i_reply[pos(0)];
		end else if (i_sclk !== prev) begin
			if ((i_sclk != i_cpol) == i_cpha) begin
				sh[pos(n)] = i_simo;
				n++;
				if (n == (i_seven ? 7 : 8)) begin
					o_rx <= sh;
					o_chars <= o_chars + 1;
					n = 0;
					o_somi <= i_reply[pos(0)];
				end
			end else begin
				o_somi <= i_reply[pos(n)];
			end
		end
	end
endmodule

// *** testbench/spi_config_bit_rate_control_tb.sv ***
module spi_config_bit_rate_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 0, rstn = 0, rd = 0, wr = 0, aux = 0, sub = 0, clr = 0, ste_in = 0;
	logic [7:0]  addr = 8'h00, reply = 8'h00, prx, tx, rp, mask;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0]  be = 4'h0;
	logic        wreq, sclk, sclk_oe, ste, ste_oe, simo, simo_oe, somi, somi_o, somi_oe, irq;
	logic        cpha = 0, cpol = 0, msb = 0, seven = 0;
	int          pchars, n_fail = 0, checks_done = 0;
	initial forever #20 clk = ~clk;
	always @(posedge clk) begin
		aux <= 1'($urandom);
		sub <= 1'($urandom);
	end
	scbr_top DUT (.i_clk_sys(clk), .i_rstn(rstn), .i_avs_address(addr), .i_avs_read(rd),
		.i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be),
		.o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_aux_clk_tick(aux),
		.i_sub_main_clk_tick(sub), .i_serial_clock_pin(cpol), .o_serial_clock_pin(sclk),
		.o_serial_clock_pin_oe(sclk_oe), .i_slave_enable_pin(ste_in), .o_slave_enable_pin(ste),
		.o_slave_enable_pin_oe(ste_oe), .i_simo_pin(1'b0), .o_simo_pin(simo),
		.o_simo_pin_oe(simo_oe), .i_somi_pin(somi), .o_somi_pin(somi_o),
		.o_somi_pin_oe(somi_oe), .o_irq(irq));
	scbr_peer PEER (.i_clk_sys(clk), .i_clr(clr), .i_sclk(sclk), .i_simo(simo), .i_cpha(cpha),
		.i_cpol(cpol), .i_msb(msb), .i_seven(seven), .i_reply(reply), .o_somi(somi),
		.o_rx(prx), .o_chars(pchars));
	task automatic end_of_test();
		$display("checks=%0d fails=%0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Request is held until waitrequest is seen low; no fixed latency assumed
	task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d,
			input logic [3:0] e, output logic [15:0] r);
		@(posedge clk);
		addr <= a;
		rd <= ~w;
		wr <= w;
		wdata <= {16'h0000, d};
		be <= e;
		do @(posedge clk); while (wreq !== 1'b0);
		r = rdata[15:0];
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic wrw(input logic [7:0] a, input logic [15:0] d, input logic [3:0] e);
		logic [15:0] r;
		bus(1'b1, a, d, e, r);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
		logic [15:0] r;
		bus(1'b0, a, 16'h0000, 4'h3, r);
		chk(r, exp);
	endtask
	task automatic xfer(input logic [7:0] t, input logic [7:0] p);
		int c;
		c = pchars;
		reply <= p;
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		wrw(8'h38, {8'h00, t}, 4'h1);
		while (pchars == c) @(posedge clk);
		repeat (8) @(posedge clk);
	endtask
	initial begin
		#1200us;
		n_fail++;
		end_of_test();
	end
	initial begin
		void'($urandom(18));
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		rdc(8'h00, 16'h01c1);
		rdc(8'h04, 16'h0001);
		rdc(8'h18, 16'h0000);
		rdc(8'h20, 16'h0000);
		rdc(8'hb0, 16'h0002);
		rdc(8'h10, 16'h0000);
		wrw(8'h1c, 16'h0012, 4'h1);
		wrw(8'h18, 16'h0034, 4'h1);
		rdc(8'h18, 16'h1234);
		wrw(8'h38, 16'h00a5, 4'h1);
		repeat (40) @(posedge clk);
		chk(16'(pchars), 16'h0000);
		rdc(8'hb0, 16'h0002);
		wrw(8'h00, 16'h01c0, 4'h3);
		wrw(8'h18, 16'h0005, 4'h3);
		rdc(8'h18, 16'h1234);
		wrw(8'h00, 16'hffff, 4'h3);
		rdc(8'h00, 16'h01c1);
		for (int i = 0; i < 8; i++) begin
			logic [15:0] ctl;
			logic [1:0]  md;
			md = 2'((i >> 1) % 3);
			cpha <= i[0];
			cpol <= i[1];
			msb <= i[2];
			seven <= i[0] ^ i[1];
			ctl = {i[0], i[1], i[2], i[0] ^ i[1], 1'b1, md, 1'b1, 2'((i % 3) + 1), 6'h03};
			wrw(8'h00, ctl, 4'h3);
			wrw(8'h18, 16'(i % 4), 4'h3);
			wrw(8'h00, ctl & 16'hfffe, 4'h3);
			wrw(8'ha8, 16'(i % 2), 4'h3);
			repeat (4) @(posedge clk);
			chk(16'(sclk), 16'(i[1]));
			chk(16'(ste_oe), 16'(md != 2'h0));
			chk(16'(ste), 16'(md != 2'h1));
			chk(16'({sclk_oe, simo_oe, somi_oe}), 16'h0006);
			rp = 8'($urandom);
			tx = 8'($urandom);
			mask = (i[0] ^ i[1]) ? 8'h7f : 8'hff;
			xfer(tx, rp);
			chk(16'(prx), 16'(tx & mask));
			chk(16'(irq), 16'(i % 2));
			if (i == 7) begin
				xfer(~tx, ~rp);
				rdc(8'h20, 16'h0020);
				rp = ~rp;
			end
			rdc(8'h30, 16'(rp & mask));
			rdc(8'h20, 16'h0000);
			rdc(8'hb0, 16'h0002);
			repeat (2) @(posedge clk);
			chk(16'(irq), 16'h0000);
		end
		xfer(8'h3c, 8'hc3);
		chk(16'(irq), 16'h0001);
		wrw(8'hc0, 16'h0001, 4'h3);
		rdc(8'hb0, 16'h0002);
		wrw(8'ha8, 16'h0002, 4'h3);
		repeat (3) @(posedge clk);
		chk(16'(irq), 16'h0001);
		wrw(8'ha8, 16'h0000, 4'h3);
		repeat (3) @(posedge clk);
		chk(16'(irq), 16'h0000);
		// Asynchronous and two-wire pin modes leave the engine and its pins idle
		for (int k = 0; k < 2; k++) begin
			wrw(8'h00, 16'h0001, 4'h3);
			wrw(8'h00, (k == 0) ? 16'h08c1 : 16'h0fc1, 4'h3);
			wrw(8'h00, (k == 0) ? 16'h08c0 : 16'h0fc0, 4'h3);
			repeat (4) @(posedge clk);
			chk(16'({sclk_oe, simo_oe}), 16'h0000);
		end
		// Another master holding the enable pin active is a bus conflict
		ste_in <= 1'b1;
		wrw(8'h00, 16'h0001, 4'h3);
		wrw(8'h00, 16'h0bc1, 4'h3);
		wrw(8'h00, 16'h0bc0, 4'h3);
		repeat (8) @(posedge clk);
		rdc(8'h20, 16'h0040);
		chk(16'(ste_oe), 16'h0000);
		end_of_test();
	end
endmodule
